// ### core/charger_event_status_mask_i2c.sv
// event status, mask and flag bank behind a serial slave port
// Notes on behaviour
// - status bit 7: CDP device found, pass-through
// - status bit 6: handshake skipped
// - status bit 2: remote wake in automatic mode
// - mask at 0x08 read/write, resets zero
// - mask bit 6 gates handshake skip flag
// - mask bit 5 gates connection check flag
// - mask bit 3 gates usb session flag
// - mask bit 2 gates remote wake flag
// - mask bit 1 gates toggle start flag
// - mask bit 0 gates toggle end flag
// - serial clock up to 400 kHz
// - first byte after start is address
// - one bit per rising clock edge
// - data edge with clock high is control
// - idle bus lines rest released high
// - answers 0x35 or 0x15 by variant
// - flag register 0x06 latches events
// - nack an invalid register address
`default_nettype none
module charger_event_status_mask_i2c #(
  parameter bit VARIANT_B = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SAMPLE_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic CDP_DEVICE_PRESENT,
  input wire logic HANDSHAKE_SKIPPED_FLAG,
  input wire logic CONNECT_CHECK_ACTIVE,
  input wire logic USB_SESSION_ACTIVE,
  input wire logic REMOTE_WAKE_PENDING,
  input wire logic VBUS_TOGGLE_DONE,
  input wire logic PASS_THROUGH_CHARGE_MODE,
  input wire logic AUTOMATIC_CHARGE_MODE,
  input wire logic HOST_SIDE_DATA_PAIR
);

  localparam logic [6:0] OWN_ADDR = VARIANT_B ?
    charger_evt_pkg::ADDR_VARIANT_B : charger_evt_pkg::ADDR_VARIANT_A;

  charger_evt_pkg::clk_st_t c_r;
  charger_evt_pkg::clk_st_t c_nxt;
  charger_evt_pkg::link_st_t l_r;
  charger_evt_pkg::link_st_t l_nxt;

  // system clock side: live status built from the charger logic
  always_comb begin
    c_nxt = c_r;
    c_nxt.status = charger_evt_pkg::STATUS_RST;
    c_nxt.status[charger_evt_pkg::BIT_CDP] =
      CDP_DEVICE_PRESENT & PASS_THROUGH_CHARGE_MODE;
    c_nxt.status[charger_evt_pkg::BIT_SKIP] =
      HANDSHAKE_SKIPPED_FLAG;
    c_nxt.status[charger_evt_pkg::BIT_CONN] =
      CONNECT_CHECK_ACTIVE;
    c_nxt.status[charger_evt_pkg::BIT_USB] = USB_SESSION_ACTIVE &
      PASS_THROUGH_CHARGE_MODE & HOST_SIDE_DATA_PAIR;
    c_nxt.status[charger_evt_pkg::BIT_WAKE] =
      REMOTE_WAKE_PENDING & AUTOMATIC_CHARGE_MODE;
    // bits 4 and 1 stay at their zero default
    c_nxt.status[charger_evt_pkg::BIT_TOG_END] =
      VBUS_TOGGLE_DONE;
    if (!RST_N) begin
      c_nxt.status = charger_evt_pkg::STATUS_RST;
    end
  end

  // system clock register
  always_ff @(posedge CLK) begin
    c_r <= c_nxt;
  end

  // sampled bus conditions from second or third sync stages, and register range checks
  logic lrst_n;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rise;
  logic [7:0] fall;
  logic reg_ok;
  logic ptr_ok;

  assign lrst_n = l_r.rs2;
  assign scl_rise = l_r.scl2 & ~l_r.scl3;
  assign scl_fall = ~l_r.scl2 & l_r.scl3;
  // sda moving while scl is high is a frame condition
  assign bus_start = l_r.scl2 & l_r.scl3 & ~l_r.sda2 & l_r.sda3;
  assign bus_stop = l_r.scl2 & l_r.scl3 & l_r.sda2 & ~l_r.sda3;
  assign rise = l_r.stat2 & ~l_r.stat3;
  assign fall = ~l_r.stat2 & l_r.stat3;
  assign reg_ok = (l_r.shift >= charger_evt_pkg::REG_FLAGS) &&
    (l_r.shift <= charger_evt_pkg::REG_MASK);
  assign ptr_ok = (l_r.ptr >= charger_evt_pkg::REG_FLAGS) &&
    (l_r.ptr <= charger_evt_pkg::REG_MASK);

  // sampling side: synchronisers, slave machine, mask and flags
  always_comb begin
    logic [7:0] rd;
    logic [7:0] clr;
    logic [7:0] set;
    logic load;
    rd = 8'h00;
    clr = 8'h00;
    set = 8'h00;
    load = 1'b0;
    l_nxt = l_r;
    // two stages before any logic looks at a pin or the other domain
    l_nxt.rs1 = RST_N;
    l_nxt.rs2 = l_r.rs1;
    l_nxt.scl1 = SCL_IN;
    l_nxt.scl2 = l_r.scl1;
    l_nxt.scl3 = l_r.scl2;
    l_nxt.sda1 = SDA_IN;
    l_nxt.sda2 = l_r.sda1;
    l_nxt.sda3 = l_r.sda2;
    // status bits are independent levels, so per-bit sync is safe
    l_nxt.stat1 = c_r.status;
    l_nxt.stat2 = l_r.stat1;
    l_nxt.stat3 = l_r.stat2;
    l_nxt.sda_o = 1'b0;
    // readback source for the register under the pointer
    if (l_r.ptr == charger_evt_pkg::REG_FLAGS) begin
      rd = l_r.flags;
    end else if (l_r.ptr == charger_evt_pkg::REG_STATUS) begin
      rd = l_r.stat2;
    end else if (l_r.ptr == charger_evt_pkg::REG_MASK) begin
      rd = l_r.mask;
    end else begin
      rd = 8'h00;
    end
    if (bus_start) begin
      // start or repeated start always opens an address byte
      l_nxt.state = charger_evt_pkg::S_RX;
      l_nxt.kind = charger_evt_pkg::K_ADDR;
      l_nxt.cnt = charger_evt_pkg::CNT_RST;
      l_nxt.sda_oe = 1'b0;
    end else if (bus_stop) begin
      l_nxt.state = charger_evt_pkg::S_IDLE;
      l_nxt.sda_oe = 1'b0;
    end else begin
      case (l_r.state)
        charger_evt_pkg::S_IDLE: begin
          l_nxt.sda_oe = 1'b0;
        end
        charger_evt_pkg::S_RX: begin
          if (scl_rise && l_r.cnt != charger_evt_pkg::BITS_PER_BYTE)
          begin
            // data is taken while scl is high
            l_nxt.shift = {l_r.shift[6:0], l_r.sda2};
            l_nxt.cnt = 4'(l_r.cnt + 4'h1);
          end else if (scl_fall &&
                       l_r.cnt == charger_evt_pkg::BITS_PER_BYTE) begin
            l_nxt.cnt = charger_evt_pkg::CNT_RST;
            l_nxt.state = charger_evt_pkg::S_IDLE;
            case (l_r.kind)
              charger_evt_pkg::K_ADDR: begin
                if (l_r.shift[7:1] == OWN_ADDR) begin
                  l_nxt.state = charger_evt_pkg::S_ACK;
                  l_nxt.sda_oe = 1'b1;
                  l_nxt.to_tx = l_r.shift[0];
                  l_nxt.kind = charger_evt_pkg::K_REG;
                end
              end
              charger_evt_pkg::K_REG: begin
                // an unknown register leaves sda released: a nack
                if (reg_ok) begin
                  l_nxt.ptr = l_r.shift;
                  l_nxt.state = charger_evt_pkg::S_ACK;
                  l_nxt.sda_oe = 1'b1;
                  l_nxt.to_tx = 1'b0;
                  l_nxt.kind = charger_evt_pkg::K_DATA;
                end
              end
              default: begin
                if (ptr_ok) begin
                  // status and flags ignore writes but still ack
                  if (l_r.ptr == charger_evt_pkg::REG_MASK) begin
                    l_nxt.mask = l_r.shift &
                      charger_evt_pkg::MASK_WR_BITS;
                  end
                  l_nxt.ptr = 8'(l_r.ptr + 8'h01);
                  l_nxt.state = charger_evt_pkg::S_ACK;
                  l_nxt.sda_oe = 1'b1;
                  l_nxt.to_tx = 1'b0;
                end
              end
            endcase
          end
        end
        charger_evt_pkg::S_ACK: begin
          // ack is held through the ninth high phase
          if (scl_fall) begin
            l_nxt.sda_oe = 1'b0;
            if (l_r.to_tx) begin
              load = 1'b1;
            end else begin
              l_nxt.state = charger_evt_pkg::S_RX;
            end
          end
        end
        charger_evt_pkg::S_TX: begin
          // bits change only while scl is low
          if (scl_fall) begin
            if (l_r.cnt != charger_evt_pkg::BITS_PER_BYTE) begin
              l_nxt.sda_oe = ~l_r.shift[6];
              l_nxt.shift = {l_r.shift[6:0], 1'b0};
              l_nxt.cnt = 4'(l_r.cnt + 4'h1);
            end else begin
              l_nxt.sda_oe = 1'b0;
              l_nxt.state = charger_evt_pkg::S_MACK;
            end
          end
        end
        charger_evt_pkg::S_MACK: begin
          if (scl_rise) begin
            if (l_r.sda2) begin
              l_nxt.state = charger_evt_pkg::S_IDLE;
            end else begin
              l_nxt.ptr = 8'(l_r.ptr + 8'h01);
              l_nxt.state = charger_evt_pkg::S_WAITF;
            end
          end
        end
        charger_evt_pkg::S_WAITF: begin
          if (scl_fall) begin
            load = 1'b1;
          end
        end
        default: begin
          l_nxt.state = charger_evt_pkg::S_IDLE;
          l_nxt.sda_oe = 1'b0;
        end
      endcase
    end
    // first bit of a read byte goes out at once
    if (load) begin
      l_nxt.state = charger_evt_pkg::S_TX;
      l_nxt.shift = rd;
      l_nxt.sda_oe = ~rd[7];
      l_nxt.cnt = charger_evt_pkg::CNT_FIRST_TX;
      if (l_r.ptr == charger_evt_pkg::REG_FLAGS) begin
        clr = rd; // only flags that were seen get cleared
      end
    end
    // flags latch gated edges; a new event beats a clear-on-read
    set = rise & l_r.mask & charger_evt_pkg::LEVEL_EVT_BITS;
    set[charger_evt_pkg::BIT_TOG_ST] =
      fall[charger_evt_pkg::BIT_TOG_END] &
      l_r.mask[charger_evt_pkg::BIT_TOG_ST];
    set[charger_evt_pkg::BIT_TOG_END] =
      rise[charger_evt_pkg::BIT_TOG_END] &
      l_r.mask[charger_evt_pkg::BIT_TOG_END];
    // check, usb and wake flags ride on the masked vector
    l_nxt.flags = (l_r.flags & ~clr) | set;
    if (!l_r.rs2) begin
      l_nxt.state = charger_evt_pkg::S_IDLE;
      l_nxt.kind = charger_evt_pkg::K_ADDR;
      l_nxt.cnt = charger_evt_pkg::CNT_RST;
      l_nxt.shift = 8'h00;
      l_nxt.ptr = 8'h00;
      l_nxt.to_tx = 1'b0;
      l_nxt.sda_oe = 1'b0;
      l_nxt.mask = charger_evt_pkg::MASK_RST;
      l_nxt.flags = charger_evt_pkg::FLAGS_RST;
    end
  end

  // sampling clock register
  always_ff @(posedge SAMPLE_CLK) begin
    l_r <= l_nxt;
  end

  assign SDA_OUT = l_r.sda_o;
  assign SDA_OE = l_r.sda_oe;

  // checks on the system clock
  reserved_zero_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !c_r.status[charger_evt_pkg::BIT_RSV_HI] &&
    !c_r.status[charger_evt_pkg::BIT_TOG_ST])
    else $error("reserved status bit set");

  cdp_detect_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    $rose(c_r.status[charger_evt_pkg::BIT_CDP]) |->
    $past(PASS_THROUGH_CHARGE_MODE))
    else $error("cdp status outside pass-through");

  wake_mode_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !AUTOMATIC_CHARGE_MODE |=> !c_r.status[charger_evt_pkg::BIT_WAKE])
    else $error("wake status outside automatic mode");

  bypass_level_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    HANDSHAKE_SKIPPED_FLAG ##1 !HANDSHAKE_SKIPPED_FLAG |->
    c_r.status[charger_evt_pkg::BIT_SKIP] ##1
    !c_r.status[charger_evt_pkg::BIT_SKIP])
    else $error("skip status does not follow");

  // checks on the sampling clock
  mask_reset_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    $rose(l_r.rs2) |-> l_r.mask == charger_evt_pkg::MASK_RST &&
    l_r.flags == charger_evt_pkg::FLAGS_RST)
    else $error("mask or flags not cleared by reset");

  skip_flag_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    rise[charger_evt_pkg::BIT_SKIP] &&
    l_r.mask[charger_evt_pkg::BIT_SKIP] |=>
    l_r.flags[charger_evt_pkg::BIT_SKIP])
    else $error("skip flag lost");

  conn_masked_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    !l_r.mask[charger_evt_pkg::BIT_CONN] &&
    !l_r.flags[charger_evt_pkg::BIT_CONN] |=>
    !l_r.flags[charger_evt_pkg::BIT_CONN])
    else $error("masked check flag raised");

  usb_wake_flag_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    $rose(l_r.flags[charger_evt_pkg::BIT_USB]) ||
    $rose(l_r.flags[charger_evt_pkg::BIT_WAKE]) |->
    $past(l_r.mask[charger_evt_pkg::BIT_USB] ||
    l_r.mask[charger_evt_pkg::BIT_WAKE]))
    else $error("usb or wake flag without enable");

  tog_start_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    fall[charger_evt_pkg::BIT_TOG_END] &&
    l_r.mask[charger_evt_pkg::BIT_TOG_ST] |=>
    l_r.flags[charger_evt_pkg::BIT_TOG_ST])
    else $error("toggle start flag lost");

  tog_end_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    rise[charger_evt_pkg::BIT_TOG_END] &&
    l_r.mask[charger_evt_pkg::BIT_TOG_END] |=>
    l_r.flags[charger_evt_pkg::BIT_TOG_END])
    else $error("toggle end flag lost");

  start_decode_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    bus_start |=> l_r.state == charger_evt_pkg::S_RX &&
    l_r.kind == charger_evt_pkg::K_ADDR && l_r.cnt == 4'h0)
    else $error("start not decoded");

  idle_release_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    l_r.state == charger_evt_pkg::S_IDLE |-> !l_r.sda_oe)
    else $error("sda driven while idle");

  sequence foreign_addr_s;
    l_r.state == charger_evt_pkg::S_RX &&
    l_r.kind == charger_evt_pkg::K_ADDR &&
    l_r.cnt == charger_evt_pkg::BITS_PER_BYTE &&
    l_r.shift[7:1] != OWN_ADDR && scl_fall && !bus_start && !bus_stop;
  endsequence

  sequence bad_reg_s;
    l_r.state == charger_evt_pkg::S_RX &&
    l_r.kind == charger_evt_pkg::K_REG &&
    l_r.cnt == charger_evt_pkg::BITS_PER_BYTE && !reg_ok &&
    scl_fall && !bus_start && !bus_stop;
  endsequence

  sequence read_acked_s;
    l_r.state == charger_evt_pkg::S_ACK && l_r.to_tx &&
    scl_fall && !bus_start && !bus_stop;
  endsequence

  foreign_addr_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    foreign_addr_s |=> !l_r.sda_oe [*2])
    else $error("ack for a foreign address");

  bad_reg_nack_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    bad_reg_s |=> l_r.state == charger_evt_pkg::S_IDLE && !l_r.sda_oe)
    else $error("invalid register acked");

  read_dir_a: assert property (
    @(posedge SAMPLE_CLK) disable iff (!lrst_n)
    read_acked_s |=> l_r.state == charger_evt_pkg::S_TX &&
    l_r.cnt == charger_evt_pkg::CNT_FIRST_TX)
    else $error("read address did not start a read");

endmodule : charger_event_status_mask_i2c
`default_nettype wire

// ### core/charger_evt_pkg.sv
// package: register map, bus codes, state types of the event bank
`default_nettype none
package charger_evt_pkg;
  // register offsets as seen over the serial port
  localparam logic [7:0] REG_FLAGS = 8'h06;
  localparam logic [7:0] REG_STATUS = 8'h07;
  localparam logic [7:0] REG_MASK = 8'h08;
  // values after reset
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // writable mask bits, bit 4 is reserved and stays zero
  localparam logic [7:0] MASK_WR_BITS = 8'hEF;
  // flags that latch on a rising status level
  localparam logic [7:0] LEVEL_EVT_BITS = 8'hEC;
  // 7-bit slave addresses of the two variants
  localparam logic [6:0] ADDR_VARIANT_A = 7'h35;
  localparam logic [6:0] ADDR_VARIANT_B = 7'h15;
  // field positions shared by status, mask and flags
  localparam int unsigned BIT_CDP = 7;
  localparam int unsigned BIT_SKIP = 6;
  localparam int unsigned BIT_CONN = 5;
  localparam int unsigned BIT_RSV_HI = 4;
  localparam int unsigned BIT_USB = 3;
  localparam int unsigned BIT_WAKE = 2;
  localparam int unsigned BIT_TOG_ST = 1;
  localparam int unsigned BIT_TOG_END = 0;
  // bus limits
  localparam int unsigned SCL_MAX_KHZ = 400;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_FIRST_TX = 4'h1;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_ACK = 3'b010,
    S_TX = 3'b011,
    S_MACK = 3'b100,
    S_WAITF = 3'b101
  } i2c_state_t;

  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_REG = 2'b01,
    K_DATA = 2'b10
  } byte_kind_t;

  // state kept on the system clock
  typedef struct packed {
    logic [7:0] status;
  } clk_st_t;

  // state kept on the sampling clock of the serial port
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] stat3;
    i2c_state_t state;
    byte_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic to_tx;
    logic sda_oe;
    logic sda_o;
    logic [7:0] mask;
    logic [7:0] flags;
  } link_st_t;
endpackage : charger_evt_pkg
`default_nettype wire

// ### tb/i2c_host_model.sv
// host controller model that masters the serial clock and data lines
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  // 157 cycles a quarter gives 2512 ns a bit, just under the top rate
  localparam int QUARTER = 157;

  // both lines released while the bus rests
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // one quarter of a serial clock period
  task automatic quarter();
    repeat (QUARTER) @(posedge clk);
  endtask : quarter

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_pull <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_pull <= 1'b1;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask : start_cond

  // stop: data rises while the clock is high, then both rest high
  task automatic stop_cond();
    sda_pull <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_pull <= 1'b0;
    quarter();
  endtask : stop_cond

  // data only changes with the clock low, sampled mid high phase
  task automatic tx_bit(input logic b, output logic r);
    sda_pull <= !b;
    quarter();
    scl <= 1'b1;
    quarter();
    r = sda;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask : tx_bit

  // eight bits msb first, then the ninth bit; sending 8'hFF releases
  // the line so that the slave can drive read data
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic nack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      tx_bit(d[i], b);
      q[i] = b;
    end
    tx_bit(last, nack);
  endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// ### tb/charger_event_status_mask_i2c_test.sv
// self-checking bench for the event status, mask and flag bank
`default_nettype none
`define CHK(g, e) check(g, e)
module charger_event_status_mask_i2c_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RST_N, SAMPLE_CLK, SDA_OUT, SDA_OE, scl, host_pull;
  logic cdp, skip, conn, usb, wake, tog_done, pass_mode, auto_mode;
  logic host_pair, nack;
  wire logic sda;
  logic [7:0] got [3];
  int bad_count = 0;
  int compares = 0;

  // open drain data wire with its pull-up
  assign sda = !(host_pull | SDA_OE);

  charger_event_status_mask_i2c #(.VARIANT_B(1'b0))
    charger_event_status_mask_i2c_i (
    .CLK(CLK), .RST_N(RST_N), .SAMPLE_CLK(SAMPLE_CLK), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .CDP_DEVICE_PRESENT(cdp), .HANDSHAKE_SKIPPED_FLAG(skip),
    .CONNECT_CHECK_ACTIVE(conn), .USB_SESSION_ACTIVE(usb),
    .REMOTE_WAKE_PENDING(wake), .VBUS_TOGGLE_DONE(tog_done),
    .PASS_THROUGH_CHARGE_MODE(pass_mode),
    .AUTOMATIC_CHARGE_MODE(auto_mode), .HOST_SIDE_DATA_PAIR(host_pair));

  i2c_host_model i2c_host_model_i (
    .clk(CLK), .sda(sda), .scl(scl), .sda_pull(host_pull));

  // system clock 4 ns
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // link clock 15 ns, phase offset so edges never line up
  initial begin
    SAMPLE_CLK = 1'b0;
    #1.3;
    forever #7.5 SAMPLE_CLK = ~SAMPLE_CLK;
  end

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic end_sim();
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // one byte from the host with the expected ninth bit from the slave
  task automatic put(input logic [7:0] d, input logic exp_nack);
    logic [7:0] dummy;
    logic n;
    i2c_host_model_i.xfer(d, 1'b1, dummy, n);
    `CHK({7'h00, n}, {7'h00, exp_nack});
  endtask : put

  // register write: address, register, data, stop
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    i2c_host_model_i.start_cond();
    put(8'h6A, 1'b0);
    put(a, 1'b0);
    put(d, 1'b0);
    i2c_host_model_i.stop_cond();
  endtask : write_reg

  // burst read of n bytes, the last one refused by the host
  task automatic read_regs(input logic [7:0] a, input int n);
    i2c_host_model_i.start_cond();
    put(8'h6A, 1'b0);
    put(a, 1'b0);
    i2c_host_model_i.start_cond();
    put(8'h6B, 1'b0);
    for (int i = 0; i < n; i++)
      i2c_host_model_i.xfer(8'hFF, i == n - 1, got[i], nack);
    i2c_host_model_i.stop_cond();
    `CHK({7'h00, SDA_OE}, 8'h00);
  endtask : read_regs

  // a hang is cut short here and counted as a mismatch
  initial begin
    repeat (99000) @(posedge CLK);
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    RST_N = 1'b0;
    {cdp, skip, conn, usb, wake} = 5'h00;
    tog_done = 1'b1;
    {pass_mode, auto_mode, host_pair} = 3'h7;
    // reset spans enough link clock edges to reach the serial side
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (20) @(posedge CLK);
    // other variant's address is not answered
    i2c_host_model_i.start_cond();
    put(8'h2A, 1'b1);
    i2c_host_model_i.stop_cond();
    // register address past the bank is refused
    i2c_host_model_i.start_cond();
    put(8'h6A, 1'b0);
    put(8'h09, 1'b1);
    i2c_host_model_i.stop_cond();
    // mask starts cleared
    read_regs(8'h08, 1);
    `CHK(got[0], 8'h00);
    // enable skip, usb, toggle start and end; cdp, check, wake stay off
    write_reg(8'h08, 8'h5B);
    {cdp, skip, conn, usb, wake} <= 5'h1F;
    tog_done <= 1'b0;
    repeat (40) @(posedge CLK);
    tog_done <= 1'b1;
    repeat (40) @(posedge CLK);
    // flags, status and mask in one burst
    read_regs(8'h06, 3);
    `CHK(got[0], 8'h4B);
    `CHK(got[1], 8'hED);
    `CHK(got[2], 8'h4B);
    `CHK({7'h00, SDA_OUT}, 8'h00);
    end_sim();
  end
endmodule : charger_event_status_mask_i2c_test
`default_nettype wire
